// ### logic/amdt_consts.svh
`ifndef AMDT_CONSTS_SVH
`define AMDT_CONSTS_SVH

// ----------------------------------------
// opcode patterns
// ----------------------------------------
`define AMDT_OPC_ASCII_ADD 8'h37
`define AMDT_OPC_DEC_ADD 8'h27
`define AMDT_OPC_ASCII_SUB 8'h3f
`define AMDT_OPC_DEC_SUB 8'h2f
`define AMDT_OPC_GRP3_HI 7'h7b
`define AMDT_OPC_SMUL_IMM_HI 6'h1a
`define AMDT_OPC_W_BIT 0
`define AMDT_OPC_S_BIT 1

// ----------------------------------------
// modrm fields
// ----------------------------------------
`define AMDT_MOD_REG 2'h3
`define AMDT_REG_UMUL 3'h4
`define AMDT_REG_SMUL 3'h5
`define AMDT_REG_DIV 3'h6

// ----------------------------------------
// execution clock counts
// ----------------------------------------
`define AMDT_CLK_ADJUST 5'h03
`define AMDT_CLK_MPY_RB 5'h0d
`define AMDT_CLK_MPY_RW 5'h15
`define AMDT_CLK_MPY_MB 5'h10
`define AMDT_CLK_MPY_MW 5'h18
`define AMDT_CLK_IMM_R 5'h15
`define AMDT_CLK_IMM_M 5'h18
`define AMDT_CLK_DIV_RB 5'h0e
`define AMDT_CLK_DIV_RW 5'h16

`endif

// ### logic/amdt_pkg.sv
`default_nettype none
package amdt_pkg;
    typedef enum logic [2:0] {
        op_none,
        op_ascii_add_adjust,
        op_decimal_add_adjust,
        op_ascii_sub_adjust,
        op_decimal_sub_adjust,
        op_unsigned_multiply,
        op_signed_multiply,
        op_unsigned_divide
    } amdt_op_t;

    typedef enum logic [2:0] {
        st_opcode,
        st_modrm,
        st_imm_lo,
        st_imm_hi,
        st_exec
    } amdt_state_t;
endpackage
`default_nettype wire

// ### logic/amdt_tmr_if.sv
`timescale 1ns/10ps
`default_nettype none
interface amdt_tmr_if #(parameter int CNT_W = 5)
(
    input wire logic clock,
    input wire logic nrst
);
    logic load;
    logic [CNT_W-1:0] count;
    logic busy;
    logic last;
    modport ctl (output load, output count, input busy, input last);
    modport tmr (input clock, input nrst, input load, input count, output busy, output last);
endinterface
`default_nettype wire

// ### logic/amdt_timer.sv
`timescale 1ns/10ps
`default_nettype none
module amdt_timer #(parameter int CNT_W = 5)
(
    amdt_tmr_if.tmr t
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (t.load)
            nxt_cnt = t.count;
        else if (cnt_ff != '0)
            nxt_cnt = cnt_ff - {{(CNT_W-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge t.clock)
    begin
        if (!t.nrst)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    assign t.busy = (cnt_ff != '0);
    assign t.last = (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// ### logic/amdt_decode.sv
// Operation
// (RULE1) 37h: ascii add adjust, 3 clocks
// (RULE2) 27h: decimal add adjust, 3 clocks
// (RULE3) 3Fh: ascii subtract adjust, 3 clocks
// (RULE4) 2Fh: decimal subtract adjust, 3 clocks
// (RULE5) group3 reg 100: unsigned multiply, 13/21/16/24
// (RULE6) group3 reg 101: signed multiply, 13/21/16/24
// (RULE7) immediate signed multiply, 21/24, s picks length
// (RULE8) group3 reg 110: divide 14/22, divide error
// (RULE9) w bit selects byte or word
`timescale 1ns/10ps
`default_nettype none
`include "amdt_consts.svh"
module amdt_decode #(parameter int CNT_W = 5)
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    output logic in_ready,
    input wire logic div_overflow,
    output amdt_pkg::amdt_op_t op_out,
    output logic word_out,
    output logic mem_out,
    output logic imm_form_out,
    output logic [15:0] imm_out,
    output logic busy,
    output logic done,
    output logic div_error,
    output logic unknown_opc
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [CNT_W-1:0] clocks_for(amdt_pkg::amdt_op_t op, logic imm,
                                                   logic word, logic mem);
        logic [4:0] c;
        c = `AMDT_CLK_ADJUST;
        if (imm)
            c = mem ? `AMDT_CLK_IMM_M : `AMDT_CLK_IMM_R;
        else if (op == amdt_pkg::op_unsigned_divide)
            c = word ? `AMDT_CLK_DIV_RW : `AMDT_CLK_DIV_RB;
        else if (op == amdt_pkg::op_unsigned_multiply || op == amdt_pkg::op_signed_multiply)
            c = mem ? (word ? `AMDT_CLK_MPY_MW : `AMDT_CLK_MPY_MB)
                    : (word ? `AMDT_CLK_MPY_RW : `AMDT_CLK_MPY_RB);
        return CNT_W'(c);
    endfunction

    amdt_tmr_if #(.CNT_W(CNT_W)) tmr_bus (.clock(clock), .nrst(nrst));

    amdt_timer #(.CNT_W(CNT_W)) u_timer (.t(tmr_bus.tmr));

    // ----------------------------------------
    // decode state
    // ----------------------------------------
    amdt_pkg::amdt_state_t state_ff, nxt_state;
    amdt_pkg::amdt_op_t op_ff, nxt_op;
    logic word_ff, nxt_word;
    logic mem_ff, nxt_mem;
    logic imm_ff, nxt_imm;
    logic sext_ff, nxt_sext;
    logic [15:0] imm_val_ff, nxt_imm_val;
    logic div_err_ff, nxt_div_err;
    logic unk_ff, nxt_unk;
    logic take;
    logic [1:0] md;
    logic [2:0] rf;

    assign in_ready = (state_ff != amdt_pkg::st_exec);
    assign take = in_valid && in_ready;
    assign md = in_byte[7:6];
    assign rf = in_byte[5:3];

    always_comb
    begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_word = word_ff;
        nxt_mem = mem_ff;
        nxt_imm = imm_ff;
        nxt_sext = sext_ff;
        nxt_imm_val = imm_val_ff;
        nxt_div_err = 1'b0;
        nxt_unk = 1'b0;
        tmr_bus.load = 1'b0;
        tmr_bus.count = '0;
        unique case (state_ff)
            amdt_pkg::st_opcode:
            begin
                if (take)
                begin
                    nxt_imm = 1'b0;
                    nxt_mem = 1'b0;
                    nxt_word = 1'b0;
                    nxt_op = amdt_pkg::op_none;
                    nxt_state = amdt_pkg::st_exec;
                    tmr_bus.load = 1'b1;
                    tmr_bus.count = clocks_for(amdt_pkg::op_none, 1'b0, 1'b0, 1'b0);
                    if (in_byte == `AMDT_OPC_ASCII_ADD)
                        nxt_op = amdt_pkg::op_ascii_add_adjust; // RULE1
                    else if (in_byte == `AMDT_OPC_DEC_ADD)
                        nxt_op = amdt_pkg::op_decimal_add_adjust; // RULE2
                    else if (in_byte == `AMDT_OPC_ASCII_SUB)
                        nxt_op = amdt_pkg::op_ascii_sub_adjust; // RULE3
                    else if (in_byte == `AMDT_OPC_DEC_SUB)
                        nxt_op = amdt_pkg::op_decimal_sub_adjust; // RULE4
                    else
                    begin
                        tmr_bus.load = 1'b0;
                        nxt_state = amdt_pkg::st_opcode;
                        if (in_byte[7:1] == `AMDT_OPC_GRP3_HI)
                        begin
                            nxt_word = in_byte[`AMDT_OPC_W_BIT]; // RULE9
                            nxt_state = amdt_pkg::st_modrm;
                        end
                        else if (in_byte[7:2] == `AMDT_OPC_SMUL_IMM_HI && in_byte[0])
                        begin
                            nxt_imm = 1'b1; // RULE7
                            nxt_word = 1'b1;
                            nxt_sext = in_byte[`AMDT_OPC_S_BIT];
                            nxt_op = amdt_pkg::op_signed_multiply;
                            nxt_state = amdt_pkg::st_modrm;
                        end
                        else
                            nxt_unk = 1'b1;
                    end
                end
            end
            amdt_pkg::st_modrm:
            begin
                if (take)
                begin
                    nxt_mem = (md != `AMDT_MOD_REG);
                    if (imm_ff)
                        nxt_state = amdt_pkg::st_imm_lo;
                    else
                    begin
                        nxt_state = amdt_pkg::st_exec;
                        if (rf == `AMDT_REG_UMUL)
                            nxt_op = amdt_pkg::op_unsigned_multiply; // RULE5
                        else if (rf == `AMDT_REG_SMUL)
                            nxt_op = amdt_pkg::op_signed_multiply; // RULE6
                        else if (rf == `AMDT_REG_DIV && md == `AMDT_MOD_REG)
                            nxt_op = amdt_pkg::op_unsigned_divide; // RULE8
                        else
                        begin
                            // compare, negate and memory divide belong to other decoders
                            nxt_state = amdt_pkg::st_opcode;
                            nxt_unk = 1'b1;
                        end
                        tmr_bus.load = (nxt_state == amdt_pkg::st_exec);
                        tmr_bus.count = clocks_for(nxt_op, 1'b0, word_ff, nxt_mem);
                    end
                end
            end
            amdt_pkg::st_imm_lo:
            begin
                if (take)
                begin
                    nxt_imm_val = {{8{sext_ff & in_byte[7]}}, in_byte};
                    if (sext_ff)
                    begin
                        nxt_state = amdt_pkg::st_exec; // RULE7
                        tmr_bus.load = 1'b1;
                        tmr_bus.count = clocks_for(op_ff, 1'b1, 1'b1, mem_ff);
                    end
                    else
                        nxt_state = amdt_pkg::st_imm_hi;
                end
            end
            amdt_pkg::st_imm_hi:
            begin
                if (take)
                begin
                    nxt_imm_val = {in_byte, imm_val_ff[7:0]};
                    nxt_state = amdt_pkg::st_exec;
                    tmr_bus.load = 1'b1;
                    tmr_bus.count = clocks_for(op_ff, 1'b1, 1'b1, mem_ff); // RULE7
                end
            end
            amdt_pkg::st_exec:
            begin
                if (tmr_bus.last)
                begin
                    nxt_state = amdt_pkg::st_opcode;
                    // datapath flags the fault only on the closing clock
                    nxt_div_err = (op_ff == amdt_pkg::op_unsigned_divide) && div_overflow; // RULE8
                end
            end
            default:
                nxt_state = amdt_pkg::st_opcode;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_ff <= amdt_pkg::st_opcode;
            op_ff <= amdt_pkg::op_none;
            word_ff <= 1'b0;
            mem_ff <= 1'b0;
            imm_ff <= 1'b0;
            sext_ff <= 1'b0;
            imm_val_ff <= 16'h0000;
            div_err_ff <= 1'b0;
            unk_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            word_ff <= nxt_word;
            mem_ff <= nxt_mem;
            imm_ff <= nxt_imm;
            sext_ff <= nxt_sext;
            imm_val_ff <= nxt_imm_val;
            div_err_ff <= nxt_div_err;
            unk_ff <= nxt_unk;
        end
    end

    assign op_out = op_ff;
    assign word_out = word_ff;
    assign mem_out = mem_ff;
    assign imm_form_out = imm_ff;
    assign imm_out = imm_val_ff;
    assign busy = (state_ff == amdt_pkg::st_exec);
    assign done = busy && tmr_bus.last;
    assign div_error = div_err_ff;
    assign unknown_opc = unk_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // repetition is capped, so long runs are measured by a counter
    logic [5:0] len_ff, nxt_len;
    logic take_op;
    always_comb
    begin
        nxt_len = busy ? 6'(len_ff + 6'h01) : 6'h00;
    end
    always_ff @(posedge clock)
    begin
        if (!nrst)
            len_ff <= 6'h00;
        else
            len_ff <= nxt_len;
    end
    assign take_op = take && (state_ff == amdt_pkg::st_opcode);

    sequence s_three(amdt_pkg::amdt_op_t o);
        (busy && !done && op_ff == o)[*2] ##1 (done && op_ff == o) ##1 !busy;
    endsequence

    property p_ascii_add;
        @(posedge clock) disable iff (!nrst)
        take_op && in_byte == 8'h37 |=> s_three(amdt_pkg::op_ascii_add_adjust);
    endproperty
    a_ascii_add: assert property (p_ascii_add) else $error("ascii add adjust timing"); // RULE1

    property p_dec_add;
        @(posedge clock) disable iff (!nrst)
        take_op && in_byte == 8'h27 |=> s_three(amdt_pkg::op_decimal_add_adjust);
    endproperty
    a_dec_add: assert property (p_dec_add) else $error("decimal add adjust timing"); // RULE2

    property p_ascii_sub;
        @(posedge clock) disable iff (!nrst)
        take_op && in_byte == 8'h3f |=> s_three(amdt_pkg::op_ascii_sub_adjust);
    endproperty
    a_ascii_sub: assert property (p_ascii_sub) else $error("ascii sub adjust timing"); // RULE3

    property p_dec_sub;
        @(posedge clock) disable iff (!nrst)
        take_op && in_byte == 8'h2f |=> s_three(amdt_pkg::op_decimal_sub_adjust);
    endproperty
    a_dec_sub: assert property (p_dec_sub) else $error("decimal sub adjust timing"); // RULE4

    property p_umul;
        @(posedge clock) disable iff (!nrst)
        done && op_ff == amdt_pkg::op_unsigned_multiply |->
            len_ff + 6'h01 == (mem_ff ? (word_ff ? 6'h18 : 6'h10) : (word_ff ? 6'h15 : 6'h0d));
    endproperty
    a_umul: assert property (p_umul) else $error("unsigned multiply length"); // RULE5

    property p_smul;
        @(posedge clock) disable iff (!nrst)
        done && op_ff == amdt_pkg::op_signed_multiply && !imm_ff |->
            len_ff + 6'h01 == (mem_ff ? (word_ff ? 6'h18 : 6'h10) : (word_ff ? 6'h15 : 6'h0d));
    endproperty
    a_smul: assert property (p_smul) else $error("signed multiply length"); // RULE6

    property p_imm_len;
        @(posedge clock) disable iff (!nrst)
        done && imm_ff |-> len_ff + 6'h01 == (mem_ff ? 6'h18 : 6'h15);
    endproperty
    a_imm_len: assert property (p_imm_len) else $error("immediate multiply length"); // RULE7

    property p_imm_bytes;
        @(posedge clock) disable iff (!nrst)
        take && state_ff == amdt_pkg::st_imm_lo |=>
            (sext_ff ? busy : state_ff == amdt_pkg::st_imm_hi);
    endproperty
    a_imm_bytes: assert property (p_imm_bytes) else $error("immediate byte count"); // RULE7

    property p_div;
        @(posedge clock) disable iff (!nrst)
        done && op_ff == amdt_pkg::op_unsigned_divide |->
            len_ff + 6'h01 == (word_ff ? 6'h16 : 6'h0e) ##1 div_error == $past(div_overflow);
    endproperty
    a_div: assert property (p_div) else $error("divide length or error"); // RULE8

    property p_wbit;
        @(posedge clock) disable iff (!nrst)
        take_op && in_byte[7:1] == 7'h7b |=> word_out == $past(in_byte[0]) && in_ready;
    endproperty
    a_wbit: assert property (p_wbit) else $error("size bit not followed"); // RULE9
endmodule
`default_nettype wire

// ### bench/tb_arith_mul_div_decode_timing.sv
`timescale 1ns/10ps
`default_nettype none
module tb_arith_mul_div_decode_timing;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic in_valid = 1'b0;
    logic [7:0] in_byte = 8'h00;
    logic div_overflow = 1'b0;
    logic in_ready;
    amdt_pkg::amdt_op_t op_out;
    logic word_out;
    logic mem_out;
    logic imm_form_out;
    logic [15:0] imm_out;
    logic busy;
    logic done;
    logic div_error;
    logic unknown_opc;
    int bad_count = 0;
    int n_checks = 0;

    amdt_decode amdt_decode_inst (
        .clock(clock),
        .nrst(nrst),
        .in_valid(in_valid),
        .in_byte(in_byte),
        .in_ready(in_ready),
        .div_overflow(div_overflow),
        .op_out(op_out),
        .word_out(word_out),
        .mem_out(mem_out),
        .imm_form_out(imm_form_out),
        .imm_out(imm_out),
        .busy(busy),
        .done(done),
        .div_error(div_error),
        .unknown_opc(unknown_opc)
    );

    always #5 clock = ~clock;

    // ----------------------------------------
    // shared helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && n_checks > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // offered byte must be accepted outside execution
    task automatic send(input logic [7:0] b);
        in_valid <= 1'b1;
        in_byte <= b;
        #1;
        check(in_ready, 1'b1);
        @(posedge clock);
    endtask

    // returns on the edge that closes the done cycle
    task automatic run(input logic [7:0] b0, b1, b2, b3, input int nb, input int n_clk,
                       input amdt_pkg::amdt_op_t op);
        int cnt;
        cnt = 0;
        send(b0);
        if (nb > 1) send(b1);
        if (nb > 2) send(b2);
        if (nb > 3) send(b3);
        in_valid <= 1'b0;
        for (int i = 0; i < 40; i++)
        begin
            #1;
            if (busy === 1'b1)
            begin
                cnt++;
                check(in_ready, 1'b0);
            end
            if (done === 1'b1) break;
            @(posedge clock);
        end
        check(cnt, n_clk);
        check(op_out, op);
        @(posedge clock);
    endtask

    // operand fields hold after done; error pulse lasts one cycle
    task automatic fmt(input logic w, m, f, input logic [15:0] imm, input logic err);
        #1;
        check(word_out, w);
        check(mem_out, m);
        check(imm_form_out, f);
        check(imm_out, imm);
        check(busy, 1'b0);
        check(div_error, err);
        @(posedge clock);
        #1;
        check(div_error, 1'b0);
        @(posedge clock);
    endtask

    task automatic bad(input logic [7:0] b0, b1, input int nb);
        send(b0);
        if (nb > 1) send(b1);
        in_valid <= 1'b0;
        #1;
        check(unknown_opc, 1'b1);
        check(busy, 1'b0);
        @(posedge clock);
        #1;
        check(unknown_opc, 1'b0);
        @(posedge clock);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        @(posedge clock);
        #1;
        check(in_ready, 1'b1);
        check(busy, 1'b0);
        check(done, 1'b0);
        check(div_error, 1'b0);
        check(unknown_opc, 1'b0);
        check(op_out, amdt_pkg::op_none);
        @(posedge clock);
        nrst <= 1'b1;
    endtask

    // reset while idle after an unknown group3 form clears the held word bit
    task automatic t_reset_mid();
        send(8'hf7);
        send(8'hc0);
        in_valid <= 1'b0;
        repeat (2) @(posedge clock);
        nrst <= 1'b0;
        @(posedge clock);
        #1;
        check(busy, 1'b0);
        check(in_ready, 1'b1);
        check(op_out, amdt_pkg::op_none);
        check(word_out, 1'b0);
        @(posedge clock);
        nrst <= 1'b1;
        run(8'h37, 8'h00, 8'h00, 8'h00, 1, 3, amdt_pkg::op_ascii_add_adjust);
    endtask

    // back to back, next opcode in the cycle after done
    task automatic t_adjust();
        run(8'h37, 8'h00, 8'h00, 8'h00, 1, 3, amdt_pkg::op_ascii_add_adjust);
        run(8'h27, 8'h00, 8'h00, 8'h00, 1, 3, amdt_pkg::op_decimal_add_adjust);
        run(8'h3f, 8'h00, 8'h00, 8'h00, 1, 3, amdt_pkg::op_ascii_sub_adjust);
        run(8'h2f, 8'h00, 8'h00, 8'h00, 1, 3, amdt_pkg::op_decimal_sub_adjust);
        @(posedge clock);
    endtask

    task automatic t_mul();
        logic [2:0] r;
        logic w;
        logic m;
        int n;
        for (int i = 0; i < 8; i++)
        begin
            r = i[2] ? 3'h5 : 3'h4;
            w = i[1];
            m = i[0];
            n = m ? (w ? 24 : 16) : (w ? 21 : 13);
            run({7'h7b, w}, {(m ? 2'h0 : 2'h3), r, 3'h0}, 8'h00, 8'h00, 2, n,
                i[2] ? amdt_pkg::op_signed_multiply
                     : amdt_pkg::op_unsigned_multiply);
            fmt(w, m, 1'b0, 16'h0000, 1'b0);
        end
    endtask

    task automatic t_imm();
        run(8'h6b, 8'hc0, 8'h05, 8'h00, 3, 21, amdt_pkg::op_signed_multiply);
        fmt(1'b1, 1'b0, 1'b1, 16'h0005, 1'b0);
        run(8'h6b, 8'h00, 8'h80, 8'h00, 3, 24, amdt_pkg::op_signed_multiply);
        fmt(1'b1, 1'b1, 1'b1, 16'hff80, 1'b0);
        run(8'h69, 8'hc0, 8'h34, 8'h12, 4, 21, amdt_pkg::op_signed_multiply);
        fmt(1'b1, 1'b0, 1'b1, 16'h1234, 1'b0);
        run(8'h69, 8'h00, 8'hcd, 8'hab, 4, 24, amdt_pkg::op_signed_multiply);
        fmt(1'b1, 1'b1, 1'b1, 16'habcd, 1'b0);
    endtask

    // overflow held through the done cycle, where it is sampled
    task automatic t_div();
        // immediate field keeps the last immediate taken
        run(8'hf6, 8'hf0, 8'h00, 8'h00, 2, 14, amdt_pkg::op_unsigned_divide);
        fmt(1'b0, 1'b0, 1'b0, 16'habcd, 1'b0);
        div_overflow <= 1'b1;
        // a fault flagged during a multiply is not a divide error
        run(8'hf6, 8'he0, 8'h00, 8'h00, 2, 13, amdt_pkg::op_unsigned_multiply);
        fmt(1'b0, 1'b0, 1'b0, 16'habcd, 1'b0);
        run(8'hf7, 8'hf0, 8'h00, 8'h00, 2, 22, amdt_pkg::op_unsigned_divide);
        div_overflow <= 1'b0;
        fmt(1'b1, 1'b0, 1'b0, 16'habcd, 1'b1);
    endtask

    // neighbours of the handled forms must not start execution
    task automatic t_unknown();
        bad(8'hf6, 8'hd8, 2);
        bad(8'hf7, 8'hf8, 2);
        bad(8'hf6, 8'h30, 2);
        bad(8'h90, 8'h00, 1);
        bad(8'h7b, 8'h00, 1);
        bad(8'h6a, 8'h00, 1);
    endtask

    initial
    begin
        t_reset();
        t_adjust();
        t_mul();
        t_imm();
        t_div();
        t_unknown();
        t_reset_mid();
        give_verdict();
    end

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    // whole run is well under 1000 cycles
    initial
    begin
        #20000;
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
